// [logic/kami_pkg.sv]
// Constants and helpers shared by the key and address-match block.
// Assumes byte-wide registers at their printed byte addresses.
//
// What this block does
// R01: Any selected edge on enabled key pins raises one key request.
// R02: A key edge on an enabled pin gives a wake-up event.
// R03: Per-pin enable bit: 0 excludes the pin, 1 includes it.
// R04: Per-pin polarity bit: 0 falling edge, 1 rising edge.
// R05: Enabled falling-type pin held low blocks edges on other pins.
// R06: Enabled rising-type pin held high blocks edges on other pins.
// R07: Rewriting key control may set the flag; software clears it after.
// R08: Two key control registers, even bits enable, odd bits polarity, reset 0.
// R09: Request a match interrupt just before executing the matched address.
// R10: Each match channel has an enable at bit 0 of its register.
// R11: Match interrupt ignores global mask flag and priority level.
// R12: Pushed PC is match address plus 2 for short forms, else plus 1.
// R13: Software loads match addresses with instruction start addresses only.
// R14: Handler fixes stacked return address or unwinds and jumps back.
// R15: Match enable bits 1 to 7 read zero and ignore writes.
// R16: Two match enable registers at own addresses, reset to disabled.
// R17: Match address register holds a 20-bit instruction address.
// R18: Gate by enable, condition by polarity, OR, edge sets flag.
package kami_pkg;
   localparam int REG_ADDR_W = 9;
   localparam int REG_DATA_W = 8;
   localparam int KEY_PINS = 8;
   localparam int MATCH_ADDR_W = 20;

   localparam logic [8:0] MATCH_ADDR0_OFF = 9'h1C0;
   localparam logic [8:0] MATCH_CH0_EN_OFF = 9'h1C3;
   localparam logic [8:0] MATCH_ADDR1_OFF = 9'h1C4;
   localparam logic [8:0] MATCH_CH1_EN_OFF = 9'h1C7;
   localparam logic [8:0] KEY_STATUS_OFF = 9'h1F8;
   localparam logic [8:0] KEY_LOW_CTRL_OFF = 9'h1FE;
   localparam logic [8:0] KEY_HIGH_CTRL_OFF = 9'h1FF;

   localparam int KEY_EN_POS = 0;
   localparam int KEY_POL_POS = 1;
   localparam int MATCH_ON_POS = 0;
   localparam int KEY_FLAG_POS = 0;
   localparam int KEY_LEVEL_POS = 1;
   localparam logic [1:0] MATCH_TOP_BYTE = 2'h2;

   localparam logic [7:0] KEY_CTRL_RST = 8'h00;
   localparam logic [7:0] MATCH_EN_RST = 8'h00;
   localparam logic [19:0] MATCH_ADDR_RST = 20'h00000;

   localparam logic [19:0] PC_STEP_SHORT = 20'h00002;
   localparam logic [19:0] PC_STEP_LONG = 20'h00001;

   // Pin is active when enabled and at its selected level
   function automatic logic key_cond(input logic en, input logic pol,
                                     input logic pin);
      return en & ~(pin ^ pol);
   endfunction

   function automatic logic [19:0] pushed_pc(input logic [19:0] addr,
                                             input logic short_form);
      return addr + (short_form ? PC_STEP_SHORT : PC_STEP_LONG);
   endfunction
endpackage

// [logic/kami_match_bank.sv]
// Two match address registers, byte written, read data registered.
// Assumes one-cycle strobes, never read and write together.
`timescale 1ns/100ps
module kami_match_bank (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Register port
   input wire logic [8:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic hit_out,
   // Stored addresses
   output logic [19:0] match_address_ch0_out,
   output logic [19:0] match_address_ch1_out
);
   logic [19:0] match_address [2];
   logic sel_valid;
   logic sel_ch;
   logic [1:0] sel_byte;
   logic [19:0] cur;

   always_comb begin
      sel_valid = 1'b0;
      sel_ch = 1'b0;
      sel_byte = addr_in[1:0];
      if (addr_in[8:2] == kami_pkg::MATCH_ADDR0_OFF[8:2] &&
          addr_in[1:0] != 2'h3) begin
         sel_valid = 1'b1;
      end else if (addr_in[8:2] == kami_pkg::MATCH_ADDR1_OFF[8:2] &&
                   addr_in[1:0] != 2'h3) begin
         sel_valid = 1'b1;
         sel_ch = 1'b1;
      end
      cur = match_address[sel_ch];
   end

   // Bits 23..20 have no storage
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         match_address[0] <= kami_pkg::MATCH_ADDR_RST;
         match_address[1] <= kami_pkg::MATCH_ADDR_RST;
      end else if (wr_in && sel_valid) begin
         case (sel_byte)
            2'h0: match_address[sel_ch][7:0] <= wdata_in; // R17
            2'h1: match_address[sel_ch][15:8] <= wdata_in; // R17
            default: match_address[sel_ch][19:16] <= wdata_in[3:0]; // R17
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         rdata_out <= 8'h00;
         hit_out <= 1'b0;
      end else begin
         hit_out <= rd_in & sel_valid;
         rdata_out <= 8'h00;
         if (rd_in && sel_valid) begin
            case (sel_byte)
               2'h0: rdata_out <= cur[7:0];
               2'h1: rdata_out <= cur[15:8];
               default: rdata_out <= {4'h0, cur[19:16]}; // R17
            endcase
         end
      end
   end

   assign match_address_ch0_out = match_address[0];
   assign match_address_ch1_out = match_address[1];
endmodule // kami_match_bank

// [logic/kami_top.sv]
// Key-input interrupt and two-channel address-match interrupt.
// Assumes key pins and fetch signals synchronous to clk_in.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
module kami_top (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,

   // Register port
   input wire logic [8:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,

   // Key pins and key request
   input wire logic [7:0] key_pin_in,
   output logic key_irq_request_out,
   output logic key_wake_out,

   // CPU instruction fetch
   input wire logic [19:0] fetch_addr_in,
   input wire logic fetch_valid_in,
   input wire logic fetch_short_in,
   output logic match_req_out,
   output logic match_channel_out,
   output logic [19:0] match_pc_out
);

   logic [7:0] key_low;
   logic [7:0] key_high;
   logic [1:0] match_on;
   logic request_flag;

   logic [7:0] key_en;
   logic [7:0] key_pol;
   logic [7:0] key_active;
   logic key_any;
   logic key_any_q;
   logic key_edge;
   logic flag_clear;

   logic [19:0] match_address_ch0;
   logic [19:0] match_address_ch1;
   logic hit0;
   logic hit1;

   logic [7:0] top_rdata;
   logic [7:0] key_status;
   logic [7:0] bank_rdata;
   logic bank_hit;

   // Register writes

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         key_low <= kami_pkg::KEY_CTRL_RST; // R08
         key_high <= kami_pkg::KEY_CTRL_RST; // R08
      end else if (reg_wr_in) begin
         if (reg_addr_in == kami_pkg::KEY_LOW_CTRL_OFF) begin
            key_low <= reg_wdata_in; // R08
         end else if (reg_addr_in == kami_pkg::KEY_HIGH_CTRL_OFF) begin
            key_high <= reg_wdata_in; // R08
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         match_on[0] <= kami_pkg::MATCH_EN_RST[0]; // R16
         match_on[1] <= kami_pkg::MATCH_EN_RST[0]; // R16
      end else if (reg_wr_in) begin
         if (reg_addr_in == kami_pkg::MATCH_CH0_EN_OFF) begin
            match_on[0] <= reg_wdata_in[kami_pkg::MATCH_ON_POS]; // R10
         end else if (reg_addr_in == kami_pkg::MATCH_CH1_EN_OFF) begin
            match_on[1] <= reg_wdata_in[kami_pkg::MATCH_ON_POS]; // R10
         end
      end
   end

   // Key detection

   // Split the two control bytes into per-pin fields
   always_comb begin
      for (int i = 0; i < kami_pkg::KEY_PINS; i++) begin
         if (i < 4) begin
            key_en[i] = key_low[2 * i + kami_pkg::KEY_EN_POS]; // R03
            key_pol[i] = key_low[2 * i + kami_pkg::KEY_POL_POS]; // R04
         end else begin
            key_en[i] = key_high[2 * (i - 4) + kami_pkg::KEY_EN_POS];
            key_pol[i] = key_high[2 * (i - 4) + kami_pkg::KEY_POL_POS];
         end
         key_active[i] = kami_pkg::key_cond(key_en[i], key_pol[i],
                                            key_pin_in[i]); // R18
      end
   end

   // A pin held at its active level keeps the OR high, masking others
   assign key_any = |key_active; // R05 R06
   assign key_edge = key_any & ~key_any_q; // R01

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         key_any_q <= 1'b0;
      end else begin
         key_any_q <= key_any; // R18
      end
   end

   assign flag_clear = reg_wr_in &&
                       reg_addr_in == kami_pkg::KEY_STATUS_OFF &&
                       !reg_wdata_in[kami_pkg::KEY_FLAG_POS];

   // Control rewrites can also make the OR rise and set the flag
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         request_flag <= 1'b0;
      end else if (key_edge) begin
         request_flag <= 1'b1; // R01 R07
      end else if (flag_clear) begin
         request_flag <= 1'b0; // R07
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         key_wake_out <= 1'b0;
      end else begin
         key_wake_out <= key_edge; // R02
      end
   end

   assign key_irq_request_out = request_flag;

   // Live OR level beside the sticky flag
   always_comb begin
      key_status = 8'h00;
      key_status[kami_pkg::KEY_LEVEL_POS] = key_any;
      key_status[kami_pkg::KEY_FLAG_POS] = request_flag;
   end

   // Address match

   kami_match_bank i_kami_match_bank (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .addr_in(reg_addr_in),
      .wdata_in(reg_wdata_in),
      .wr_in(reg_wr_in),
      .rd_in(reg_rd_in),
      .rdata_out(bank_rdata),
      .hit_out(bank_hit),
      .match_address_ch0_out(match_address_ch0),
      .match_address_ch1_out(match_address_ch1)
   );

   assign hit0 = match_on[0] && fetch_addr_in == match_address_ch0;
   assign hit1 = match_on[1] && fetch_addr_in == match_address_ch1;

   // No mask flag or priority level enters this request
   assign match_req_out = fetch_valid_in & (hit0 | hit1); // R09 R11

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         match_channel_out <= 1'b0;
         match_pc_out <= kami_pkg::MATCH_ADDR_RST;
      end else if (match_req_out) begin
         match_channel_out <= ~hit0;
         match_pc_out <= kami_pkg::pushed_pc(fetch_addr_in,
                                             fetch_short_in); // R12
      end
   end

   // Register reads

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         top_rdata <= 8'h00;
      end else if (!reg_rd_in) begin
         top_rdata <= 8'h00;
      end else if (reg_addr_in == kami_pkg::KEY_LOW_CTRL_OFF) begin
         top_rdata <= key_low; // R08
      end else if (reg_addr_in == kami_pkg::KEY_HIGH_CTRL_OFF) begin
         top_rdata <= key_high; // R08
      end else if (reg_addr_in == kami_pkg::MATCH_CH0_EN_OFF) begin
         top_rdata <= {7'h00, match_on[0]}; // R15
      end else if (reg_addr_in == kami_pkg::MATCH_CH1_EN_OFF) begin
         top_rdata <= {7'h00, match_on[1]}; // R15
      end else if (reg_addr_in == kami_pkg::KEY_STATUS_OFF) begin
         top_rdata <= key_status;
      end else begin
         top_rdata <= 8'h00;
      end
   end

   assign reg_rdata_out = bank_hit ? bank_rdata : top_rdata;

   // Checks

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   a_key_edge_sets: assert property ( // R01
      key_any && !key_any_q |=> key_irq_request_out
   ) else $error("key edge did not set request flag");

   a_wake_pulse: assert property ( // R02
      $rose(key_any) |=> key_wake_out ##1 !key_wake_out
   ) else $error("wake pulse missing or too long");

   a_pin_disabled: assert property ( // R03
      key_en == 8'h00 |-> !key_any ##1 !key_wake_out
   ) else $error("disabled pins raised key activity");

   a_falling_active: assert property ( // R04
      key_en[0] && !key_pol[0] && !key_pin_in[0] |-> key_any
   ) else $error("low level on falling pin not seen");

   a_rising_active: assert property ( // R04
      key_en[4] && key_pol[4] && key_pin_in[4] |-> key_any
   ) else $error("high level on rising pin not seen");

   a_held_masks: assert property ( // R05
      key_any_q && key_any |=> !key_wake_out
   ) else $error("edge seen while another pin held active");

   a_flag_clears: assert property ( // R07
      flag_clear && !key_edge |=> !key_irq_request_out
   ) else $error("request flag did not clear");

   a_flag_sticky: assert property ( // R07
      key_irq_request_out && !flag_clear |=> key_irq_request_out
   ) else $error("request flag dropped without clear");

   a_set_beats_clear: assert property ( // R07
      flag_clear && key_edge |=> key_irq_request_out
   ) else $error("clear won over a new key edge");

   a_key_ctrl_read: assert property ( // R08
      reg_rd_in && reg_addr_in == kami_pkg::KEY_LOW_CTRL_OFF
      |=> reg_rdata_out == $past(key_low)
   ) else $error("key low control read mismatch");

   a_match_hits: assert property ( // R09
      fetch_valid_in && match_on[1] &&
      fetch_addr_in == match_address_ch1 |-> match_req_out
   ) else $error("enabled match channel gave no request");

   a_match_off: assert property ( // R10
      match_on == 2'b00 |-> !match_req_out
   ) else $error("request with both channels disabled");

   a_pc_short: assert property ( // R12
      match_req_out && fetch_short_in
      |=> match_pc_out == $past(fetch_addr_in) + 20'h00002
   ) else $error("short form pushed pc wrong");

   a_pc_long: assert property ( // R12
      match_req_out && !fetch_short_in
      |=> match_pc_out == $past(fetch_addr_in) + 20'h00001
   ) else $error("long form pushed pc wrong");

   a_enable_reserved: assert property ( // R15
      reg_rd_in && reg_addr_in == kami_pkg::MATCH_CH1_EN_OFF
      |=> reg_rdata_out[7:1] == 7'h00
   ) else $error("reserved match enable bits not zero");

   a_enable_read: assert property ( // R16
      reg_rd_in && reg_addr_in == kami_pkg::MATCH_CH0_EN_OFF
      |=> reg_rdata_out[0] == match_on[0]
   ) else $error("match enable read mismatch");

   a_addr_top: assert property ( // R17
      reg_rd_in && reg_addr_in ==
      {kami_pkg::MATCH_ADDR0_OFF[8:2], kami_pkg::MATCH_TOP_BYTE}
      |=> reg_rdata_out[7:4] == 4'h0
   ) else $error("unused match address bits not zero");

   a_flag_needs_edge: assert property ( // R01
      !key_irq_request_out && !key_edge |=> !key_irq_request_out
   ) else $error("request flag rose without a key edge");

   a_wake_follows: assert property ( // R02
      key_edge |=> key_wake_out
   ) else $error("key edge gave no wake event");

   a_wake_quiet: assert property ( // R02
      !key_edge |=> !key_wake_out
   ) else $error("wake event without a key edge");

   a_falling_held: assert property ( // R05
      key_en[0] && !key_pol[0] && !key_pin_in[0] &&
      $past(key_active[0]) |-> !key_edge
   ) else $error("edge taken while falling pin held low");

   a_rising_held: assert property ( // R06
      key_en[4] && key_pol[4] && key_pin_in[4] &&
      $past(key_active[4]) |-> !key_edge
   ) else $error("edge taken while rising pin held high");

   a_key_high_read: assert property ( // R08
      reg_rd_in && reg_addr_in == kami_pkg::KEY_HIGH_CTRL_OFF
      |=> reg_rdata_out == $past(key_high)
   ) else $error("key high control read mismatch");

   a_status_read: assert property ( // R07
      reg_rd_in && reg_addr_in == kami_pkg::KEY_STATUS_OFF
      |=> reg_rdata_out[kami_pkg::KEY_FLAG_POS] == $past(request_flag)
   ) else $error("status flag read mismatch");

   a_no_fetch: assert property ( // R09
      !fetch_valid_in |-> !match_req_out
   ) else $error("match request without a valid fetch");

   a_ch0_hits: assert property ( // R09
      fetch_valid_in && match_on[0] &&
      fetch_addr_in == match_address_ch0 |-> match_req_out
   ) else $error("enabled channel 0 gave no request");

   a_ch0_priority: assert property ( // R09
      match_req_out && hit0 |=> !match_channel_out
   ) else $error("channel 0 hit not reported as channel 0");

   a_ch1_reported: assert property ( // R09
      match_req_out && !hit0 |=> match_channel_out
   ) else $error("channel 1 hit not reported as channel 1");

   a_ch0_off: assert property ( // R10
      !match_on[0] && !hit1 |-> !match_req_out
   ) else $error("request from disabled channel 0");

   a_ch1_off: assert property ( // R10
      !match_on[1] && !hit0 |-> !match_req_out
   ) else $error("request from disabled channel 1");

   a_pc_holds: assert property ( // R12
      !match_req_out |=> $stable(match_pc_out)
   ) else $error("pushed pc changed without a request");

   a_reserved_ch0: assert property ( // R15
      reg_rd_in && reg_addr_in == kami_pkg::MATCH_CH0_EN_OFF
      |=> reg_rdata_out[7:1] == 7'h00
   ) else $error("reserved channel 0 enable bits not zero");

   a_enable_ch1_read: assert property ( // R16
      reg_rd_in && reg_addr_in == kami_pkg::MATCH_CH1_EN_OFF
      |=> reg_rdata_out[0] == $past(match_on[1])
   ) else $error("channel 1 enable read mismatch");

   a_match_addr_top: assert property ( // R17
      reg_rd_in && reg_addr_in ==
      {kami_pkg::MATCH_ADDR1_OFF[8:2], kami_pkg::MATCH_TOP_BYTE}
      |=> reg_rdata_out == {4'h0, $past(match_address_ch1[19:16])}
   ) else $error("channel 1 top address byte read mismatch");

endmodule // kami_top

// [verification/kami_far_model.sv]
// Behavioural key switches and CPU fetch stage facing the block.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/100ps
module kami_far_model (
   // Clock
   input wire logic clk_in,
   // Key switches
   output logic [7:0] key_pin_out,
   // Instruction fetch
   output logic [19:0] fetch_addr_out,
   output logic fetch_valid_out,
   output logic fetch_short_out
);
   initial begin
      key_pin_out = 8'hFF;
      fetch_addr_out = 20'h00000;
      fetch_valid_out = 1'b0;
      fetch_short_out = 1'b0;
   end

   // Switch levels change just after an edge and then hold
   task automatic set_keys(input logic [7:0] lvl);
      @(posedge clk_in);
      key_pin_out <= lvl;
   endtask

   // Only first addresses of instructions are ever presented
   task automatic present(input logic [19:0] a, input logic s);
      @(posedge clk_in);
      fetch_addr_out <= a;
      fetch_short_out <= s;
      fetch_valid_out <= 1'b1;
   endtask

   // Idle fetch bus shows a changed address, never the last one
   task automatic withdraw();
      @(posedge clk_in);
      fetch_valid_out <= 1'b0;
      fetch_addr_out <= ~fetch_addr_out;
      fetch_short_out <= ~fetch_short_out;
   endtask
endmodule // kami_far_model

// [verification/kami_tb_top.sv]
// Self-checking bench for the key and address-match block.
// Assumes the far-side model in kami_far_model drives pins and fetch.
`timescale 1ns/100ps
module kami_tb_top;
   logic clk_in;
   logic rst_b_in;
   logic [8:0] reg_addr_in;
   logic [7:0] reg_wdata_in;
   logic reg_wr_in;
   logic reg_rd_in;
   logic [7:0] reg_rdata_out;
   logic [7:0] key_pin_in;
   logic key_irq_request_out;
   logic key_wake_out;
   logic [19:0] fetch_addr_in;
   logic fetch_valid_in;
   logic fetch_short_in;
   logic match_req_out;
   logic match_channel_out;
   logic [19:0] match_pc_out;
   int error_cnt = 0;
   int compares = 0;
   int wake_cnt = 0;

   kami_top i_kami_top (
      .clk_in(clk_in), .rst_b_in(rst_b_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .key_pin_in(key_pin_in),
      .key_irq_request_out(key_irq_request_out),
      .key_wake_out(key_wake_out), .fetch_addr_in(fetch_addr_in),
      .fetch_valid_in(fetch_valid_in), .fetch_short_in(fetch_short_in),
      .match_req_out(match_req_out), .match_channel_out(match_channel_out),
      .match_pc_out(match_pc_out));

   kami_far_model i_kami_far_model (
      .clk_in(clk_in), .key_pin_out(key_pin_in),
      .fetch_addr_out(fetch_addr_in), .fetch_valid_out(fetch_valid_in),
      .fetch_short_out(fetch_short_in));

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // Wake pulses are one cycle long, so count them as they pass
   always @(posedge clk_in) begin
      if (key_wake_out === 1'b1) begin
         wake_cnt++;
      end
   end

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [19:0] got, input logic [19:0] exp,
                      input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [8:0] a, input logic [7:0] exp,
                     input string what);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk({12'h000, reg_rdata_out}, {12'h000, exp}, what);
   endtask

   task automatic clr_flag();
      wr(9'h1F8, 8'h00);
   endtask

   task automatic key_evt(input logic [7:0] lvl, input logic exp_flag,
                          input int exp_wakes);
      int w0;
      w0 = wake_cnt;
      i_kami_far_model.set_keys(lvl);
      repeat (3) @(posedge clk_in);
      #1;
      chk({19'h00000, key_irq_request_out}, {19'h00000, exp_flag}, "flag");
      chk(20'(wake_cnt - w0), 20'(exp_wakes), "wake pulses");
   endtask

   task automatic fetch(input logic [19:0] a, input logic s,
                        input logic req, input logic [19:0] pc,
                        input logic ch);
      i_kami_far_model.present(a, s);
      #1;
      chk({19'h00000, match_req_out}, {19'h00000, req}, "match request");
      i_kami_far_model.withdraw();
      #1;
      if (req) begin
         chk(match_pc_out, pc, "pushed pc");
         chk({19'h00000, match_channel_out}, {19'h00000, ch}, "channel");
      end
   endtask

   initial begin
      #20000;
      error_cnt++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      wrap_up();
   end

   initial begin
      rst_b_in = 1'b0;
      reg_addr_in = 9'h000;
      reg_wdata_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'b1;
      rd(9'h1C3, 8'h00, "ch0 enable reset");
      rd(9'h1C7, 8'h00, "ch1 enable reset");
      rd(9'h1FE, 8'h00, "key low reset");
      rd(9'h1FF, 8'h00, "key high reset");
      rd(9'h100, 8'h00, "unmapped read");
      wr(9'h1C3, 8'hFF);
      rd(9'h1C3, 8'h01, "ch0 enable unused bits");
      wr(9'h1C7, 8'hFE);
      rd(9'h1C7, 8'h00, "ch1 enable unused bits");
      wr(9'h1FF, 8'h5A);
      rd(9'h1FF, 8'h5A, "key high readback");
      wr(9'h1FF, 8'h00);
      // Key pin 0 falling
      wr(9'h1FE, 8'h01);
      clr_flag();
      key_evt(8'hFE, 1'b1, 1);
      clr_flag();
      rd(9'h1F8, 8'h02, "status after clear");
      // Pin 0 held low blocks pin 2
      wr(9'h1FE, 8'h11);
      clr_flag();
      key_evt(8'hFA, 1'b0, 0);
      key_evt(8'hFF, 1'b0, 0);
      key_evt(8'h7F, 1'b0, 0);
      key_evt(8'hFF, 1'b0, 0);
      // Pin 4 rising, high at setup
      wr(9'h1FF, 8'h03);
      repeat (2) @(posedge clk_in);
      #1;
      chk({19'h00000, key_irq_request_out}, 20'h00001, "setup flag");
      clr_flag();
      key_evt(8'hEF, 1'b0, 0);
      key_evt(8'hFF, 1'b1, 1);
      clr_flag();
      key_evt(8'hFE, 1'b0, 0);
      // Key edge and flag clear in one cycle
      key_evt(8'hEF, 1'b0, 0);
      fork
         i_kami_far_model.set_keys(8'hFF);
         clr_flag();
      join
      repeat (2) @(posedge clk_in);
      #1;
      chk({19'h00000, key_irq_request_out}, 20'h00001, "set wins");
      // Match addresses 0x12345 and 0xFFFFF
      wr(9'h1C3, 8'h00);
      wr(9'h1C0, 8'h45);
      wr(9'h1C1, 8'h23);
      wr(9'h1C2, 8'hF1);
      rd(9'h1C2, 8'h01, "ch0 top byte");
      wr(9'h1C4, 8'hFF);
      wr(9'h1C5, 8'hFF);
      wr(9'h1C6, 8'h0F);
      rd(9'h1C6, 8'h0F, "ch1 top byte");
      fetch(20'h12345, 1'b0, 1'b0, 20'h00000, 1'b0);
      wr(9'h1C3, 8'h01);
      fetch(20'h12345, 1'b0, 1'b1, 20'h12346, 1'b0);
      fetch(20'h12345, 1'b1, 1'b1, 20'h12347, 1'b0);
      fetch(20'h12344, 1'b0, 1'b0, 20'h00000, 1'b0);
      fetch(20'hFFFFF, 1'b1, 1'b0, 20'h00000, 1'b0);
      wr(9'h1C7, 8'h01);
      fetch(20'hFFFFF, 1'b1, 1'b1, 20'h00001, 1'b1);
      fetch(20'hFFFFF, 1'b0, 1'b1, 20'h00000, 1'b1);
      wrap_up();
   end
endmodule // kami_tb_top
